// ### pkg/otgr_pkg.sv
// Constants and carrier types for the OTG limit and ADC readback register bank
package otgr_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] OTGR_CMD_ADC_BUS_SYSTEM_POWER_MONITOR = 8'h23;
    localparam logic [7:0] OTGR_CMD_OTG_VOLTAGE = 8'h3B;
    localparam logic [7:0] OTGR_CMD_OTG_CURRENT = 8'h3C;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int OTGR_VOLT_LSB = 2;
    localparam int OTGR_VOLT_W = 12;
    localparam int OTGR_CURR_LSB = 8;
    localparam int OTGR_CURR_W = 7;
    localparam int OTGR_ADC_BUS_LSB = 8;
    localparam logic [15:0] OTGR_VOLT_RSVD_HI = 16'hC000;
    localparam logic [15:0] OTGR_CURR_RSVD_HI = 16'h8000;
    localparam logic [15:0] OTGR_VOLT_KEEP = 16'h3FFC;
    localparam logic [15:0] OTGR_CURR_KEEP = 16'h7F00;
    localparam logic [15:0] OTGR_VOLT_RESET = 16'h0000;
    localparam logic [15:0] OTGR_CURR_RESET = 16'h0000;
    localparam logic [15:0] OTGR_ADC_RESET = 16'h0000;
    localparam logic [15:0] OTGR_UNMAPPED_READ = 16'h0000;

    // ------------------------------------------------------------
    // Voltage scale, in units of 0.1 mV so that 8.1 mV stays exact
    // ------------------------------------------------------------
    localparam int OTGR_DAC_W = 20;
    localparam logic [OTGR_DAC_W-1:0] OTGR_VOLT_WEIGHT [OTGR_VOLT_W] = '{
        20'h00051, 20'h000A0, 20'h0014A, 20'h0028A, 20'h00514, 20'h00A28,
        20'h0145A, 20'h028AA, 20'h05154, 20'h0A2A8, 20'h14550, 20'h28AA0
    };  // 8.1, 16, 33, 65, 130, 260, 521, 1041, 2082, 4164, 8328, 16656 mV
    localparam logic [OTGR_DAC_W-1:0] OTGR_DAC_OFFSET = 20'h03200;  // 1.28 V
    localparam logic [OTGR_DAC_W-1:0] OTGR_DAC_MIN = 20'h07530;     // 3 V
    localparam logic [OTGR_DAC_W-1:0] OTGR_DAC_MAX = 20'h32C80;     // 20.8 V

    // ------------------------------------------------------------
    // Current scale
    // ------------------------------------------------------------
    localparam int OTGR_CURR_MA_W = 13;
    localparam logic [5:0] OTGR_CURR_STEP_MA = 6'h32;  // 50 mA per code

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] cmd;
        logic [15:0] wdata;
    } otgr_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] bus_code;
        logic [7:0] system_power_monitor_code;
    } otgr_adc_t;

    typedef struct packed {
        logic [15:0] volt;
        logic [15:0] curr;
        logic [15:0] adc;
        logic [15:0] rdata;
        logic rvalid;
        logic wr_reject;
        logic [OTGR_DAC_W-1:0] dac;
        logic [OTGR_CURR_MA_W-1:0] cur_ma;
    } otgr_state_t;

endpackage

// ### src/otgr_dac_calc.sv
// OTG voltage DAC target: weighted sum, optional offset, range check and clamp
`timescale 1ns/1ps

module otgr_dac_calc
(
    input wire logic [15:0] word,                                   // Register word to evaluate
    input wire logic offset_disable,                                // High removes the fixed offset
    output logic [otgr_pkg::OTGR_DAC_W-1:0] target,                 // Unclamped target, 0.1 mV units
    output logic in_range,                                          // Target within min..max
    output logic [otgr_pkg::OTGR_DAC_W-1:0] clamped                 // Target clamped into range
);

    always_comb
    begin
        target = '0;
        for (int i = 0; i < otgr_pkg::OTGR_VOLT_W; i++)
        begin
            if (word[otgr_pkg::OTGR_VOLT_LSB + i])
            begin
                target = target + otgr_pkg::OTGR_VOLT_WEIGHT[i];  // R2
            end
        end
        if (!offset_disable)
        begin
            target = target + otgr_pkg::OTGR_DAC_OFFSET;  // R5 R15
        end
        in_range = (target >= otgr_pkg::OTGR_DAC_MIN) && (target <= otgr_pkg::OTGR_DAC_MAX);  // R15
        if (target < otgr_pkg::OTGR_DAC_MIN)
        begin
            clamped = otgr_pkg::OTGR_DAC_MIN;  // R3
        end
        else if (target > otgr_pkg::OTGR_DAC_MAX)
        begin
            clamped = otgr_pkg::OTGR_DAC_MAX;  // R3
        end
        else
        begin
            clamped = target;
        end
    end

endmodule // otgr_dac_calc

// ### src/otgr_regs.sv
// OTG voltage and current limit registers with the bus voltage / system power ADC word
`timescale 1ns/1ps

// Function
// R1 - Command 3Bh write stores OTG voltage
// R2 - 12-bit voltage field, bits 13..2, weighted sum
// R3 - DAC command clamped to 3 V .. 20.8 V
// R4 - Out-of-range voltage write is discarded
// R5 - Offset bit clear adds 1.28 V
// R6 - Voltage register resets to zero
// R7 - Command 3Ch write stores OTG current
// R8 - 7-bit current field, bits 14..8, 50 mA
// R9 - Current register resets to zero
// R10 - Upper reserved bits set make write invalid
// R11 - Lower reserved bits are ignored
// R12 - Command 23h reports system power monitor
// R13 - Same word reports input bus voltage
// R14 - Bus voltage high byte, power low byte
// R15 - Target is sum plus offset, then checked
module otgr_regs
(
    input wire logic clock,                                         // 200 MHz clock
    input wire logic rst_b,                                         // Asynchronous reset, active low
    input otgr_pkg::otgr_req_t req,                                 // Decoded command port
    input otgr_pkg::otgr_adc_t adc,                                 // ADC results with valid strobe
    input wire logic otg_dac_offset_disable_bit,                    // High removes the DAC offset
    output logic [15:0] rd_data,                                    // Read word
    output logic rd_valid,                                          // Read word valid pulse
    output logic wr_reject,                                         // Write discarded pulse
    output logic [otgr_pkg::OTGR_DAC_W-1:0] otg_dac_cmd,            // DAC command, 0.1 mV units
    output logic [otgr_pkg::OTGR_CURR_MA_W-1:0] otg_current_limit_ma // OTG current limit in mA
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    otgr_pkg::otgr_state_t state_q;
    otgr_pkg::otgr_state_t state_d;
    // Of the incoming word's DAC evaluation only the range verdict is needed; with the reserved-bit check it decides accept or discard
    logic new_in_range;
    logic [otgr_pkg::OTGR_DAC_W-1:0] cur_clamped;

    // ------------------------------------------------------------
    // DAC evaluation of the incoming word and of the stored setpoint
    // ------------------------------------------------------------
    otgr_dac_calc u_calc_new
    (
        .word(req.wdata),
        .offset_disable(otg_dac_offset_disable_bit),
        .target(),
        .in_range(new_in_range),
        .clamped()
    );

    // The offset bit may change after a write, so the live command is clamped too
    otgr_dac_calc u_calc_cur
    (
        .word(state_q.volt),
        .offset_disable(otg_dac_offset_disable_bit),
        .target(),
        .in_range(),
        .clamped(cur_clamped)
    );

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        OTGR_SEL_NONE = 2'h0,
        OTGR_SEL_ADC = 2'h1,
        OTGR_SEL_VOLT = 2'h2,
        OTGR_SEL_CURR = 2'h3
    } otgr_sel_t;

    // Write and read steer by this one decode, so the two sides never disagree on the map
    function automatic otgr_sel_t decode_sel
    (
        input logic [7:0] cmd
    );
        unique case (cmd)
            otgr_pkg::OTGR_CMD_ADC_BUS_SYSTEM_POWER_MONITOR:
            begin
                decode_sel = OTGR_SEL_ADC;
            end
            otgr_pkg::OTGR_CMD_OTG_VOLTAGE:
            begin
                decode_sel = OTGR_SEL_VOLT;
            end
            otgr_pkg::OTGR_CMD_OTG_CURRENT:
            begin
                decode_sel = OTGR_SEL_CURR;
            end
            default:
            begin
                decode_sel = OTGR_SEL_NONE;
            end
        endcase
    endfunction

    // One set upper reserved bit spoils the whole word
    function automatic logic rsvd_clear
    (
        input logic [15:0] word,
        input logic [15:0] rsvd_mask
    );
        rsvd_clear = ((word & rsvd_mask) == '0);
    endfunction

    // The product of a 7-bit code and the step always fits the result width
    function automatic logic [otgr_pkg::OTGR_CURR_MA_W-1:0] limit_ma
    (
        input logic [15:0] word
    );
        limit_ma = otgr_pkg::OTGR_CURR_MA_W'(
            word[otgr_pkg::OTGR_CURR_LSB +: otgr_pkg::OTGR_CURR_W] * otgr_pkg::OTGR_CURR_STEP_MA);  // R8
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        state_d.rvalid = 1'b0;
        state_d.wr_reject = 1'b0;
        // A fresh result replaces the whole word, so a read never sees half of it
        if (adc.valid)
        begin
            state_d.adc = {adc.bus_code, adc.system_power_monitor_code};  // R12 R13 R14
        end
        if (req.wr)
        begin
            unique case (decode_sel(req.cmd))
                OTGR_SEL_VOLT:
                begin
                    // Range is judged with the offset bit as it stands during the write
                    if (!rsvd_clear(req.wdata, otgr_pkg::OTGR_VOLT_RSVD_HI) || !new_in_range)
                    begin
                        state_d.wr_reject = 1'b1;  // R4 R10
                    end
                    else
                    begin
                        state_d.volt = req.wdata & otgr_pkg::OTGR_VOLT_KEEP;  // R1 R11
                    end
                end
                OTGR_SEL_CURR:
                begin
                    if (!rsvd_clear(req.wdata, otgr_pkg::OTGR_CURR_RSVD_HI))
                    begin
                        state_d.wr_reject = 1'b1;  // R10
                    end
                    else
                    begin
                        state_d.curr = req.wdata & otgr_pkg::OTGR_CURR_KEEP;  // R7 R11
                    end
                end
                OTGR_SEL_ADC, OTGR_SEL_NONE:
                begin
                    // Writes to read-only or unknown codes change no register but raise wr_reject
                    state_d.wr_reject = 1'b1;
                end
            endcase
        end
        // A read takes the stored word, so a write in the same cycle shows on the next read
        if (req.rd)
        begin
            state_d.rvalid = 1'b1;
            unique case (decode_sel(req.cmd))
                OTGR_SEL_ADC:
                begin
                    state_d.rdata = state_q.adc;  // R12 R13
                end
                OTGR_SEL_VOLT:
                begin
                    state_d.rdata = state_q.volt;
                end
                OTGR_SEL_CURR:
                begin
                    state_d.rdata = state_q.curr;
                end
                OTGR_SEL_NONE:
                begin
                    state_d.rdata = otgr_pkg::OTGR_UNMAPPED_READ;
                end
            endcase
        end
        state_d.dac = cur_clamped;  // R3
        state_d.cur_ma = limit_ma(state_q.curr);  // R8
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= '0;
            state_q.volt <= otgr_pkg::OTGR_VOLT_RESET;  // R6
            state_q.curr <= otgr_pkg::OTGR_CURR_RESET;  // R9
            state_q.adc <= otgr_pkg::OTGR_ADC_RESET;
            // The DAC command rests at the floor of its range, never at zero
            state_q.dac <= otgr_pkg::OTGR_DAC_MIN;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output comes straight from a flip-flop
    assign rd_data = state_q.rdata;
    assign rd_valid = state_q.rvalid;
    assign wr_reject = state_q.wr_reject;
    assign otg_dac_cmd = state_q.dac;
    assign otg_current_limit_ma = state_q.cur_ma;

endmodule // otgr_regs

// ### verification/otgr_host_model.sv
// Host model driving the register command port
`timescale 1ns/1ps
module otgr_host_model
(
    input wire logic clock, // Clock
    output otgr_pkg::otgr_req_t req // Command port
);
    initial req = '0;
    // One-cycle request, raised and dropped just after an edge
    task automatic xfer(input logic wr, input logic rd, input logic [7:0] cmd, input logic [15:0] wd);
        @(posedge clock);
        req <= '{wr: wr, rd: rd, cmd: cmd, wdata: wd};
        @(posedge clock);
        req <= '0;
    endtask
endmodule // otgr_host_model

// ### verification/otgr_regs_sva.sv
// Port assertions for the OTG register bank
`timescale 1ns/1ps
module otgr_regs_sva
(
    input wire logic clock, // Clock
    input wire logic rst_b, // Reset
    input otgr_pkg::otgr_req_t req, // Command
    input otgr_pkg::otgr_adc_t adc, // ADC codes
    input wire logic otg_dac_offset_disable_bit, // Offset off
    input wire logic [15:0] rd_data, // Read word
    input wire logic rd_valid, // Read pulse
    input wire logic wr_reject, // Discard pulse
    input wire logic [otgr_pkg::OTGR_DAC_W-1:0] otg_dac_cmd, // DAC
    input wire logic [otgr_pkg::OTGR_CURR_MA_W-1:0] otg_current_limit_ma // Limit
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    sequence s_cur_wr;
        req.wr && req.cmd == 8'h3C && !req.wdata[15];
    endsequence
    sequence s_adc_rd;
        adc.valid ##1 !adc.valid ##1 (req.rd && req.cmd == 8'h23);
    endsequence
    a_read_answer: assert property (req.rd |=> rd_valid) else $error("read not answered");
    a_read_quiet: assert property (!req.rd |=> !rd_valid) else $error("stray read pulse");
    a_dac_range: assert property (otg_dac_cmd >= 20'h07530 && otg_dac_cmd <= 20'h32C80)
        else $error("dac out of range");
    a_volt_rsvd: assert property (req.wr && req.cmd == 8'h3B && req.wdata[15:14] != 2'h0 |=> wr_reject)
        else $error("volt reserved write kept");
    a_curr_rsvd: assert property (req.wr && req.cmd == 8'h3C && req.wdata[15] |=> wr_reject)
        else $error("curr reserved write kept");
    a_cur_weight: assert property (s_cur_wr |=> !wr_reject ##1
        otg_current_limit_ma == 13'($past(req.wdata[14:8], 2)) * 13'h0032) else $error("limit wrong");
    a_cur_hold: assert property ((!req.wr) [*2] |=> $stable(otg_current_limit_ma))
        else $error("limit moved");
    a_adc_word: assert property (s_adc_rd |=> rd_data == {$past(adc.bus_code, 3), $past(adc.system_power_monitor_code, 3)})
        else $error("adc word wrong");
endmodule // otgr_regs_sva

bind otgr_regs otgr_regs_sva chk_u (.clock(clock), .rst_b(rst_b), .req(req), .adc(adc),
    .otg_dac_offset_disable_bit(otg_dac_offset_disable_bit), .rd_data(rd_data), .rd_valid(rd_valid),
    .wr_reject(wr_reject), .otg_dac_cmd(otg_dac_cmd), .otg_current_limit_ma(otg_current_limit_ma));

// ### verification/tb_top.sv
// Self-checking bench for the OTG register bank
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] wd;
        logic od;
        logic [15:0] rw;
        logic rj;
        logic [19:0] dac;
        logic [12:0] ma;
    } otgr_row_t;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic odis = 1'b0;
    otgr_pkg::otgr_req_t req;
    otgr_pkg::otgr_adc_t adc = '0;
    logic [15:0] rd_data;
    logic rd_valid;
    logic wr_reject;
    logic [19:0] dac;
    logic [12:0] ma;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    otgr_row_t rows [10] = '{
        {8'h3C, 16'h7F00, 1'h0, 16'h7F00, 1'h0, 20'h07530, 13'h18CE},
        {8'h3C, 16'h01FF, 1'h0, 16'h0100, 1'h0, 20'h07530, 13'h0032},
        {8'h3C, 16'h8100, 1'h0, 16'h0100, 1'h1, 20'h07530, 13'h0032},
        {8'h3B, 16'h2000, 1'h0, 16'h2000, 1'h0, 20'h2BCA0, 13'h0032},
        {8'h3B, 16'h2003, 1'h1, 16'h2000, 1'h0, 20'h28AA0, 13'h0032},
        {8'h3B, 16'h3FFC, 1'h1, 16'h2000, 1'h1, 20'h28AA0, 13'h0032},
        {8'h3B, 16'h0004, 1'h0, 16'h2000, 1'h1, 20'h2BCA0, 13'h0032},
        {8'h3B, 16'h4000, 1'h0, 16'h2000, 1'h1, 20'h2BCA0, 13'h0032},
        {8'h3B, 16'h1000, 1'h0, 16'h1000, 1'h0, 20'h17750, 13'h0032},
        {8'h3B, 16'h0400, 1'h0, 16'h0400, 1'h0, 20'h08354, 13'h0032}};
    otgr_host_model host_u (.clock(clock), .req(req));
    otgr_regs dut_u (.clock(clock), .rst_b(rst_b), .req(req), .adc(adc), .otg_dac_offset_disable_bit(odis),
        .rd_data(rd_data), .rd_valid(rd_valid), .wr_reject(wr_reject), .otg_dac_cmd(dac),
        .otg_current_limit_ma(ma));
    always #2.5 clock = ~clock;
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
        host_u.xfer(1'b0, 1'b1, cmd, 16'h0000);
        #1;
        chk(20'(rd_valid), 20'h00001);
        chk(20'(rd_data), 20'(exp));
    endtask
    // Hang guard, well above the fewer than a hundred cycles the run needs
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            error_cnt++;
            conclude();
        end
    end
    initial
    begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge clock);
            odis <= rows[i].od;
            host_u.xfer(1'b1, 1'b0, rows[i].cmd, rows[i].wd);
            #1;
            chk(20'(wr_reject), 20'(rows[i].rj));
            rd_chk(rows[i].cmd, rows[i].rw);
            chk(dac, rows[i].dac);
            chk(20'(ma), 20'(rows[i].ma));
        end
        @(posedge clock);
        adc <= '{valid: 1'b1, bus_code: 8'hA5, system_power_monitor_code: 8'h3C};
        @(posedge clock);
        adc <= '0;
        rd_chk(8'h23, 16'hA53C);
        host_u.xfer(1'b1, 1'b0, 8'h23, 16'hFFFF);
        #1;
        chk(20'(wr_reject), 20'h00001);
        rd_chk(8'h23, 16'hA53C);
        rd_chk(8'h50, 16'h0000);
        host_u.xfer(1'b1, 1'b1, 8'h3C, 16'h0200);
        #1;
        chk(20'(rd_data), 20'h00100);
        @(posedge clock);
        rst_b <= 1'b0;
        @(posedge clock);
        rst_b <= 1'b1;
        rd_chk(8'h3B, 16'h0000);
        rd_chk(8'h3C, 16'h0000);
        chk(dac, 20'h07530);
        chk(20'(ma), 20'h00000);
        conclude();
    end
endmodule // tb_top
